/* File: hdl/dcc_pkg.sv */
package dcc_pkg;

    // Register byte addresses on the APB port.
    localparam logic [11:0] CSR_OFS = 12'h000;
    localparam logic [11:0] DLW_OFS = 12'h004;
    localparam logic [11:0] MPW_OFS = 12'h008;

    // Control/status word fields.
    localparam int CSR_DRDY = 0;
    localparam int CSR_FUNC_LO = 1;
    localparam int CSR_FUNC_HI = 3;
    localparam int CSR_IE = 6;
    localparam int CSR_RDY = 7;
    localparam int CSR_OPI = 10;
    localparam int CSR_DCHK = 11;
    localparam int CSR_DFLT = 14;
    localparam int CSR_ERR = 15;

    // Disk location word fields.
    localparam int DLW_MARK_LO = 0;
    localparam int DLW_MARK_HI = 1;
    localparam int DLW_DIR = 2;
    localparam int DLW_RST = 3;
    localparam int DLW_HEAD = 4;
    localparam int DLW_DIFF_LO = 7;
    localparam int DLW_DIFF_HI = 15;

    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONES = 16'hFFFF;
    localparam logic [15:0] MPW_RESET = 16'h0000;
    localparam logic [15:0] DLW_RESET = 16'h0000;
    localparam int SECTOR_WORDS = 128;
    localparam int CYL_W = 9;
    localparam logic [8:0] CYL_MAX_DEF = 9'h0FF;

    typedef enum logic [2:0] {
        FN_NOP, FN_WCHK, FN_GSTAT, FN_SEEK,
        FN_RHDR, FN_WDATA, FN_RDATA, FN_RDNH
    } dcc_func_t;

    // Live fault and state levels reported by the drive.
    typedef struct packed {
        logic head_current_fault;
        logic write_protect_flag;
        logic seek_overrun_flag;
        logic spin_fault;
        logic write_gate_fault;
        logic unit_select_fault;
        logic extended_mode;
        logic drive_phase_bit2;
        logic drive_phase_bit1;
        logic drive_phase_bit0;
    } dcc_drv_stat_t;

    typedef struct packed {
        logic dir;
        logic head_choice;
        logic [8:0] diff;
    } dcc_seek_t;

endpackage

/* File: hdl/dcc_silo.sv */
`timescale 1ns/100ps
`default_nettype none
// Small queue of words that follow the multipurpose word.
module dcc_silo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [DEPTH*WIDTH-1:0] load_words,
    input wire logic flush,
    input wire logic pop,
    output logic [WIDTH-1:0] head_word,
    output logic not_empty
);
    logic [WIDTH-1:0] ent_r [DEPTH];
    logic [WIDTH-1:0] ent_nxt [DEPTH];
    logic [DEPTH:0] cnt_r;
    logic [DEPTH:0] cnt_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_comb begin
                ent_nxt[gi] = ent_r[gi];
                if (load) begin
                    ent_nxt[gi] = load_words[gi*WIDTH +: WIDTH];
                end else if (pop && gi < DEPTH - 1) begin
                    ent_nxt[gi] = ent_r[(gi + 1) % DEPTH];
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ent_r[gi] <= '0;
                end else begin
                    ent_r[gi] <= ent_nxt[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = (DEPTH+1)'(DEPTH);
        end else if (flush) begin
            cnt_nxt = '0;
        end else if (pop && cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign head_word = ent_r[0];
    assign not_empty = (cnt_r != '0);
endmodule
`default_nettype wire

/* File: hdl/dcc_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// Function
// - Status reset clears drive faults before delivery
// - Get status loads word, ready, interrupt
// - Status bits 15,9,5 zero; 4,3 one
// - Status reports the six drive faults
// - Status shows extended mode and head
// - Status low bits show drive phase
// - Read header queues location, zero, check
// - Header word holds cylinder, head, sector
// - Counter preloaded negative, ends on overflow
// - Function taken from control bits 1-3
// - No-op clears errors except drive fault
// - Write check matches header then streams
// - Sector compare mismatch sets data check
// - Get status without request bit errors
// - Seek needs marker bits else error
// - Seek stops at limit tracks
// - Read header captures location, ready, interrupt
// - Interrupt on any termination when enabled
// - Function codes zero to seven decoded
module dcc_ctrl #(
    parameter logic [8:0] CYL_MAX = dcc_pkg::CYL_MAX_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dcc_pkg::dcc_drv_stat_t drv_stat,
    input wire logic drive_ready,
    input wire logic [5:0] sector_index,
    input wire logic [15:0] header_check_code,
    input wire logic disk_valid,
    input wire logic [15:0] disk_word,
    input wire logic disk_crc_err,
    output logic disk_ready,
    input wire logic host_valid,
    input wire logic [15:0] host_word,
    output logic host_ready,
    output logic seek_valid,
    output dcc_pkg::dcc_seek_t seek_cmd,
    output logic irq
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_SCLR, ST_SLOAD, ST_HDR, ST_DATA
    } dcc_state_t;

    dcc_state_t state_r, state_nxt;
    dcc_pkg::dcc_func_t func_r, func_nxt;
    logic ie_r, ie_nxt, rdy_r, rdy_nxt;
    logic opi_r, opi_nxt, dchk_r, dchk_nxt;
    logic [5:0] flt_r, flt_nxt;
    logic [15:0] dlw_r, dlw_nxt, mpw_r, mpw_nxt;
    logic [8:0] cyl_r, cyl_nxt;
    logic head_r, head_nxt;
    logic [6:0] wcnt_r, wcnt_nxt;
    logic seek_valid_nxt, irq_nxt;
    dcc_pkg::dcc_seek_t seek_cmd_nxt;
    logic [31:0] prdata_nxt;

    logic wr_acc, rd_setup, rd_mpw, start, finish, xfer;
    logic flt_clr, silo_load, silo_ne;
    logic [15:0] csr_word, status_word, loc_word, silo_head;
    logic [5:0] flt_live;
    logic [9:0] cyl_sum;
    logic [8:0] seek_diff;

    assign pready = 1'b1;
    assign pslverr = psel && penable && paddr != dcc_pkg::CSR_OFS
        && paddr != dcc_pkg::DLW_OFS && paddr != dcc_pkg::MPW_OFS;
    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign rd_mpw = psel && penable && !pwrite
        && paddr == dcc_pkg::MPW_OFS;
    // Clearing the ready bit with a control write launches a command.
    assign start = wr_acc && paddr == dcc_pkg::CSR_OFS && rdy_r
        && !pwdata[dcc_pkg::CSR_RDY];
    assign xfer = state_r == ST_DATA && disk_valid && host_valid;

    assign csr_word = {opi_r || dchk_r || (flt_r != '0),
        (flt_r != '0), 2'h0, dchk_r, opi_r, 2'h0, rdy_r, ie_r, 2'h0,
        func_r, drive_ready};
    assign flt_live = {drv_stat.head_current_fault,
        drv_stat.write_protect_flag, drv_stat.seek_overrun_flag,
        drv_stat.spin_fault, drv_stat.write_gate_fault,
        drv_stat.unit_select_fault};
    assign status_word = {1'h0, flt_r[5:1], 1'h0, flt_r[0],
        drv_stat.extended_mode, head_r, 1'h0, 1'h1, 1'h1,
        drv_stat.drive_phase_bit2, drv_stat.drive_phase_bit1,
        drv_stat.drive_phase_bit0};
    assign loc_word = {cyl_r, head_r, sector_index};
    assign seek_diff = dlw_r[dcc_pkg::DLW_DIFF_HI:dcc_pkg::DLW_DIFF_LO];
    assign cyl_sum = {1'b0, cyl_r} + {1'b0, seek_diff};
    assign disk_ready = state_r == ST_HDR
        || (state_r == ST_DATA && host_valid);
    assign host_ready = state_r == ST_DATA && disk_valid;
    assign silo_load = start && dcc_pkg::FN_RHDR == dcc_pkg::dcc_func_t'(
        pwdata[dcc_pkg::CSR_FUNC_HI:dcc_pkg::CSR_FUNC_LO]);

    // The check code sits behind the zero word for diagnostic reads.
    dcc_silo #(.WIDTH(16), .DEPTH(2)) u_silo (
        .pclk(pclk),
        .presetn(presetn),
        .load(silo_load),
        .load_words({header_check_code, dcc_pkg::WORD_ZERO}),
        .flush(wr_acc && paddr == dcc_pkg::MPW_OFS),
        .pop(rd_mpw && rdy_r),
        .head_word(silo_head),
        .not_empty(silo_ne)
    );

    always_comb begin
        state_nxt = state_r;
        func_nxt = func_r;
        ie_nxt = ie_r;
        rdy_nxt = rdy_r;
        opi_nxt = opi_r;
        dchk_nxt = dchk_r;
        dlw_nxt = dlw_r;
        mpw_nxt = mpw_r;
        cyl_nxt = cyl_r;
        head_nxt = head_r;
        wcnt_nxt = wcnt_r;
        seek_valid_nxt = 1'b0;
        seek_cmd_nxt = seek_cmd;
        flt_clr = 1'b0;
        finish = 1'b0;
        if (wr_acc && paddr == dcc_pkg::CSR_OFS) begin
            ie_nxt = pwdata[dcc_pkg::CSR_IE];
        end
        if (wr_acc && rdy_r && paddr == dcc_pkg::DLW_OFS) begin
            dlw_nxt = pwdata[15:0];
        end
        if (wr_acc && rdy_r && paddr == dcc_pkg::MPW_OFS) begin
            mpw_nxt = pwdata[15:0];
        end
        if (rd_mpw && rdy_r && silo_ne) begin
            mpw_nxt = silo_head;
        end
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    func_nxt = dcc_pkg::dcc_func_t'(
                        pwdata[dcc_pkg::CSR_FUNC_HI:dcc_pkg::CSR_FUNC_LO]);
                    rdy_nxt = 1'b0;
                    case (func_nxt)
                        dcc_pkg::FN_NOP: begin
                            opi_nxt = 1'b0;
                            dchk_nxt = 1'b0;
                            finish = 1'b1;
                        end
                        dcc_pkg::FN_WCHK: begin
                            wcnt_nxt = '0;
                            state_nxt = ST_HDR;
                        end
                        dcc_pkg::FN_GSTAT: begin
                            if (!dlw_r[dcc_pkg::DLW_MARK_HI]) begin
                                opi_nxt = 1'b1;
                                finish = 1'b1;
                            end else if (dlw_r[dcc_pkg::DLW_RST]) begin
                                state_nxt = ST_SCLR;
                            end else begin
                                state_nxt = ST_SLOAD;
                            end
                        end
                        dcc_pkg::FN_SEEK: begin
                            if (dlw_r[dcc_pkg::DLW_MARK_LO]
                                && !dlw_r[dcc_pkg::DLW_MARK_HI]) begin
                                seek_valid_nxt = 1'b1;
                                seek_cmd_nxt = {dlw_r[dcc_pkg::DLW_DIR],
                                    dlw_r[dcc_pkg::DLW_HEAD], seek_diff};
                                head_nxt = dlw_r[dcc_pkg::DLW_HEAD];
                                if (dlw_r[dcc_pkg::DLW_DIR]) begin
                                    cyl_nxt = (cyl_sum > {1'b0, CYL_MAX})
                                        ? CYL_MAX : cyl_sum[8:0];
                                end else begin
                                    cyl_nxt = (seek_diff > cyl_r)
                                        ? '0 : cyl_r - seek_diff;
                                end
                            end else begin
                                opi_nxt = 1'b1;
                            end
                            finish = 1'b1;
                        end
                        dcc_pkg::FN_RHDR: begin
                            mpw_nxt = loc_word;
                            finish = 1'b1;
                        end
                        default: begin
                            // Data read and write functions are not implemented and end with an operation error.
                            opi_nxt = 1'b1;
                            finish = 1'b1;
                        end
                    endcase
                end
            end
            ST_SCLR: begin
                flt_clr = 1'b1;
                state_nxt = ST_SLOAD;
            end
            ST_SLOAD: begin
                mpw_nxt = status_word;
                finish = 1'b1;
                state_nxt = ST_IDLE;
            end
            ST_HDR: begin
                // The logical address maps one to one onto the disk.
                if (disk_valid && disk_word == dlw_r) begin
                    if (disk_crc_err) begin
                        opi_nxt = 1'b1;
                        dchk_nxt = 1'b1;
                        finish = 1'b1;
                        state_nxt = ST_IDLE;
                    end else begin
                        state_nxt = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (xfer) begin
                    mpw_nxt = mpw_r + 16'h0001;
                    wcnt_nxt = wcnt_r + 7'h01;
                    if (disk_word != host_word || disk_crc_err) begin
                        dchk_nxt = 1'b1;
                    end
                    if (mpw_r == dcc_pkg::WORD_ONES) begin
                        finish = 1'b1;
                        state_nxt = ST_IDLE;
                    end else if (wcnt_r == 7'(dcc_pkg::SECTOR_WORDS - 1))
                    begin
                        dlw_nxt = dlw_r + 16'h0001;
                        state_nxt = ST_HDR;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (finish) begin
            rdy_nxt = 1'b1;
        end
        // The enable written with the command governs its own completion.
        irq_nxt = finish && ie_nxt;
    end

    // A fault seen in the clearing cycle stays set.
    always_comb begin
        flt_nxt = (flt_clr ? '0 : flt_r) | flt_live;
    end

    // Data is registered at setup; busy reads return the raw counter.
    always_comb begin
        prdata_nxt = prdata;
        if (rd_setup) begin
            case (paddr)
                dcc_pkg::CSR_OFS: prdata_nxt = {16'h0000, csr_word};
                dcc_pkg::DLW_OFS: prdata_nxt = {16'h0000, dlw_r};
                dcc_pkg::MPW_OFS: prdata_nxt = {16'h0000, mpw_r};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            func_r <= dcc_pkg::FN_NOP;
            ie_r <= 1'b0;
            rdy_r <= 1'b1;
            opi_r <= 1'b0;
            dchk_r <= 1'b0;
            flt_r <= '0;
            dlw_r <= dcc_pkg::DLW_RESET;
            mpw_r <= dcc_pkg::MPW_RESET;
            cyl_r <= '0;
            head_r <= 1'b0;
            wcnt_r <= '0;
            seek_valid <= 1'b0;
            seek_cmd <= '0;
            irq <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            func_r <= func_nxt;
            ie_r <= ie_nxt;
            rdy_r <= rdy_nxt;
            opi_r <= opi_nxt;
            dchk_r <= dchk_nxt;
            flt_r <= flt_nxt;
            dlw_r <= dlw_nxt;
            mpw_r <= mpw_nxt;
            cyl_r <= cyl_nxt;
            head_r <= head_nxt;
            wcnt_r <= wcnt_nxt;
            seek_valid <= seek_valid_nxt;
            seek_cmd <= seek_cmd_nxt;
            irq <= irq_nxt;
            prdata <= prdata_nxt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_reset_then_load: assert property (
        state_r == ST_SCLR |=> state_r == ST_SLOAD ##1 rdy_r)
        else $error("status reset did not precede load");
    chk_status_fixed: assert property (
        state_r == ST_SLOAD |=> mpw_r[15] == 1'b0 && mpw_r[9] == 1'b0
            && mpw_r[5] == 1'b0 && mpw_r[4] && mpw_r[3])
        else $error("fixed status bits wrong");
    chk_status_done: assert property (
        state_r == ST_SLOAD |=> rdy_r && state_r == ST_IDLE)
        else $error("get status did not complete");
    chk_irq_gate: assert property (
        $rose(rdy_r) |-> irq == $past(ie_r))
        else $error("interrupt not tied to enable at completion");
    chk_gs_undef: assert property (
        start && pwdata[3:1] == 3'h2 && !dlw_r[1] |=> opi_r && rdy_r)
        else $error("undefined get status gave no error");
    chk_seek_bad: assert property (
        start && pwdata[3:1] == 3'h3 && !(dlw_r[0] && !dlw_r[1])
            |=> opi_r && !seek_valid)
        else $error("bad seek not refused");
    chk_seek_limit: assert property (
        cyl_r <= CYL_MAX)
        else $error("heads beyond limit track");
    chk_hdr_capture: assert property (
        start && pwdata[3:1] == 3'h4
            |=> mpw_r == $past(loc_word) && rdy_r ##1 silo_ne)
        else $error("read header capture wrong");
    chk_nop_clear: assert property (
        start && pwdata[3:1] == 3'h0 |=> !opi_r && !dchk_r && rdy_r)
        else $error("no-op did not clear errors");
    chk_count_step: assert property (
        xfer |=> mpw_r == $past(mpw_r) + 16'h0001)
        else $error("word counter did not step");
    chk_count_end: assert property (
        xfer && mpw_r == 16'hFFFF |=> rdy_r && state_r == ST_IDLE)
        else $error("overflow did not end transfer");
    chk_compare_err: assert property (
        xfer && disk_word != host_word |=> dchk_r)
        else $error("mismatch did not set data check");

    cov_status_reset: cover property (state_r == ST_SCLR ##2 rdy_r);
    cov_seek_ok: cover property (seek_valid);
    cov_wchk_done: cover property (
        state_r == ST_DATA ##1 state_r == ST_IDLE && rdy_r);
    cov_sector_next: cover property (
        state_r == ST_DATA ##1 state_r == ST_HDR);
endmodule
`default_nettype wire

/* File: testbench/dcc_drive_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Disk and host-memory word streams for write check.
// Released lines show the inverse, so a stale value never passes a compare.
module dcc_drive_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic active,
    input wire logic corrupt,
    input wire logic [15:0] target,
    input wire logic disk_ready,
    input wire logic host_ready,
    output logic disk_valid,
    output logic [15:0] disk_word,
    output logic disk_crc_err,
    output logic host_valid,
    output logic [15:0] host_word
);
    logic [15:0] didx_r;
    logic [15:0] hidx_r;
    logic [15:0] dw;
    logic [15:0] hw;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            didx_r <= 16'h0000;
            hidx_r <= 16'h0000;
        end else if (!active) begin
            didx_r <= 16'h0000;
            hidx_r <= 16'h0000;
        end else begin
            if (disk_valid && disk_ready) didx_r <= didx_r + 16'h0001;
            if (host_valid && host_ready) hidx_r <= hidx_r + 16'h0001;
        end
    end
    // One wrong header, then the wanted one, then the sector data.
    assign dw = (didx_r == 16'h0000) ? ~target :
                (didx_r == 16'h0001) ? target : 16'h5A00 + didx_r;
    assign hw = (16'h5A02 + hidx_r) ^ {15'h0000, corrupt};
    assign disk_valid = active;
    assign host_valid = active;
    assign disk_word = active ? dw : ~dw;
    assign host_word = active ? hw : ~hw;
    assign disk_crc_err = 1'b0;
endmodule
`default_nettype wire

/* File: testbench/disk_controller_command_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module disk_controller_command_regs_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    dcc_pkg::dcc_drv_stat_t drv_stat = 10'h000;
    logic [5:0] sector_index = 6'h25;
    logic [15:0] hcc = 16'hC3A7;
    logic disk_valid, disk_crc_err, disk_ready, host_valid, host_ready;
    logic [15:0] disk_word, host_word;
    logic seek_valid, irq, err_r;
    dcc_pkg::dcc_seek_t seek_cmd, seek_seen;
    logic active = 1'b0;
    logic corrupt = 1'b0;
    logic [15:0] target = 16'h1234;
    int num_errors = 0;
    int samples_checked = 0;
    int irq_cnt = 0;
    int seek_cnt = 0;

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (irq === 1'b1) irq_cnt++;
        if (seek_valid === 1'b1) begin
            seek_cnt++;
            seek_seen = seek_cmd;
        end
    end

    dcc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .drv_stat(drv_stat), .drive_ready(1'b1),
        .sector_index(sector_index), .header_check_code(hcc),
        .disk_valid(disk_valid), .disk_word(disk_word),
        .disk_crc_err(disk_crc_err), .disk_ready(disk_ready),
        .host_valid(host_valid), .host_word(host_word),
        .host_ready(host_ready), .seek_valid(seek_valid),
        .seek_cmd(seek_cmd), .irq(irq));
    dcc_drive_model drive (.pclk(pclk), .presetn(presetn), .active(active),
        .corrupt(corrupt), .target(target), .disk_ready(disk_ready),
        .host_ready(host_ready), .disk_valid(disk_valid),
        .disk_word(disk_word), .disk_crc_err(disk_crc_err),
        .host_valid(host_valid), .host_word(host_word));

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err_r = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 50) begin
            num_errors++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] junk;
        apb(1'b1, a, d, junk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        apb(1'b0, a, 32'h0, d);
    endtask
    // Starts a command and polls ready; checks the interrupt count after.
    task automatic run(input logic [2:0] f, input logic ie,
                       output logic [31:0] csr);
        int n;
        int i0;
        i0 = irq_cnt;
        wr(dcc_pkg::CSR_OFS, {25'h0, ie, 2'b00, f, 1'b0});
        n = 0;
        do begin
            rd(dcc_pkg::CSR_OFS, csr);
            n++;
        end while (csr[7] !== 1'b1 && n < 500);
        if (n >= 500) begin
            num_errors++;
            end_sim();
        end
        chk("irq", irq_cnt - i0, {31'h0, ie});
    endtask
    function automatic logic [15:0] stat_word(input logic [9:0] s,
                                              input logic hd);
        return {1'b0, s[9:5], 1'b0, s[4], s[3], hd, 3'b011, s[2:0]};
    endfunction

    task automatic t_reset();
        logic [31:0] d;
        rd(dcc_pkg::CSR_OFS, d);
        chk("csr", d, 32'h0000_0081);
        rd(dcc_pkg::DLW_OFS, d);
        chk("dlw", d, 32'h0);
        rd(dcc_pkg::MPW_OFS, d);
        chk("mpw", d, 32'h0);
        rd(12'h00C, d);
        chk("unmapped", {31'h0, err_r}, 32'h1);
    endtask
    task automatic t_status();
        logic [31:0] c, d;
        drv_stat <= 10'h2DD;
        wr(dcc_pkg::DLW_OFS, 32'h0003);
        run(dcc_pkg::FN_GSTAT, 1'b1, c);
        rd(dcc_pkg::MPW_OFS, d);
        chk("status", d, {16'h0, stat_word(10'h2DD, 1'b0)});
        chk("drv fault", c[14], 32'h1);
        wr(dcc_pkg::DLW_OFS, 32'h0001);
        run(dcc_pkg::FN_GSTAT, 1'b0, c);
        chk("no request", c[10], 32'h1);
        drv_stat <= 10'h004;
        run(dcc_pkg::FN_NOP, 1'b1, c);
        chk("nop clr", {c[14], c[10]}, 32'h2);
        wr(dcc_pkg::DLW_OFS, 32'h000B);
        run(dcc_pkg::FN_GSTAT, 1'b1, c);
        rd(dcc_pkg::MPW_OFS, d);
        chk("status rst", d, {16'h0, stat_word(10'h004, 1'b0)});
        chk("fault gone", c[14], 32'h0);
    endtask
    task automatic t_seek();
        logic [31:0] c, d;
        int s0;
        s0 = seek_cnt;
        wr(dcc_pkg::DLW_OFS, 32'hFF91);
        run(dcc_pkg::FN_SEEK, 1'b1, c);
        chk("seek out", {16'(seek_cnt - s0), 5'h0, seek_seen},
            32'h0001_03FF);
        run(dcc_pkg::FN_RHDR, 1'b1, c);
        rd(dcc_pkg::MPW_OFS, d);
        chk("hdr cyl 0", d, 32'h0065);
        rd(dcc_pkg::MPW_OFS, d);
        chk("hdr zero", d, 32'h0);
        rd(dcc_pkg::MPW_OFS, d);
        chk("hdr check", d, {16'h0, hcc});
        wr(dcc_pkg::DLW_OFS, 32'hFF95);
        run(dcc_pkg::FN_SEEK, 1'b0, c);
        run(dcc_pkg::FN_RHDR, 1'b0, c);
        rd(dcc_pkg::MPW_OFS, d);
        chk("hdr cyl max", d, {16'h0, 9'h0FF, 7'h65});
        wr(dcc_pkg::DLW_OFS, 32'h0003);
        run(dcc_pkg::FN_SEEK, 1'b0, c);
        chk("bad seek", {31'(seek_cnt - s0), c[10]}, 32'h5);
        run(dcc_pkg::FN_GSTAT, 1'b0, c);
        rd(dcc_pkg::MPW_OFS, d);
        chk("head bit", d[6], 32'h1);
    endtask
    task automatic t_unsup();
        logic [31:0] c;
        for (int f = 5; f < 8; f++) begin
            run(f[2:0], 1'b1, c);
            chk("unsupported", c[10], 32'h1);
            run(dcc_pkg::FN_NOP, 1'b0, c);
        end
    endtask
    task automatic t_wchk(input logic bad);
        logic [31:0] c, d;
        corrupt <= bad;
        wr(dcc_pkg::DLW_OFS, {16'h0, target});
        wr(dcc_pkg::MPW_OFS, 32'hFFFC);
        active <= 1'b1;
        run(dcc_pkg::FN_WCHK, 1'b1, c);
        active <= 1'b0;
        chk("data check", {c[11], c[10]}, {30'h0, bad, 1'b0});
        rd(dcc_pkg::MPW_OFS, d);
        chk("count wrap", d, 32'h0);
        run(dcc_pkg::FN_NOP, 1'b0, c);
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_status();
        t_seek();
        t_unsup();
        t_wchk(1'b0);
        t_wchk(1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
